// *** rtl/scsr_clock_select.sv ***
// Module: clock source select, postscaler, glitch-free switch and reference clock output
`timescale 1ns/1ps

// Operation
// - Source select 11 internal postscaled, 01 secondary, 00 primary, 10 reserved.
// - Any reset clears source select to zero, primary clock.
// - Writing new source select bits moves the clock after a short transition.
// - Primary is postscaler when config 000/001, otherwise core divider output.
// - Frequency field picks 8 MHz down to 31 kHz in powers of two.
// - Frequency field resets to the 4 MHz setting.
// - Frequency field change takes effect immediately on the internal clock.
// - At 000, low-frequency bit picks fast oscillator /256 or slow RC.
// - Watchdog always runs from slow RC oscillator.
// - Start-up status reads 1 once timer expired and primary running.
// - Start-up status resets 0 with two-speed start-up, else 1.
// - Secondary-running bit set while secondary oscillator clocks the device.
// - At most one of the two clock status bits is set.
// - Idle enable bit chooses idle or full sleep for halt instruction.
// - Secondary select ignored unless crystal enabled or digital input configured.
// - Switch is glitch-free: two old cycles plus up to three new cycles pause.
// - Reference output enable drives reference clock onto the output pin.
// - Divisor 0000 passes base clock, 0001 divides by 2.
// - Higher divisor codes divide by larger powers of two, up to 32768.
// - Reference source bit picks primary crystal, else current system clock.
// - Reference runs in sleep only with sleep-continue, source bit, EC/HS mode.
module scsr_clock_select #(
  parameter int DIV_WIDTH = 15
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Avalon-MM slave
  input  wire logic [13:0]          address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [3:0]           byteenable,
  input  wire logic [31:0]          writedata,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // Oscillator sources and configuration straps
  input  wire scsr_pkg::scsr_osc_t  osc,
  input  wire logic [2:0]           primaryOscConfig,
  input  wire logic                 secondaryDigitalInput,
  input  wire logic                 twoSpeedStartup,
  input  wire logic                 startupTimerDone,
  input  wire logic                 extOrHsMode,
  input  wire logic                 sleepActive,
  // Clock outputs
  output logic                      deviceClk,
  output logic                      watchdogClk,
  output logic                      haltEntersIdle,
  output logic                      referenceOutputPin,
  output logic                      referenceOutputEn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    scsr_pkg::scsr_cfg_t  cfg;
    scsr_pkg::scsr_src_t  activeSrc;
    scsr_pkg::scsr_src_t  pendSrc;
    scsr_pkg::scsr_sw_t   swState;
    logic [2:0]           swCount;
    logic                 prevOld;
    logic                 prevNew;
    logic                 devClk;
    logic                 startupStatus;
    logic                 statusInit;
    logic [7:0]           postDiv;
    logic                 prevFast;
    logic [DIV_WIDTH-1:0] refCnt;
    logic                 prevBase;
    logic                 refOut;
    logic                 ack;
    logic [31:0]          rdData;
  } scsr_state_t;

  scsr_state_t stateReg;
  scsr_state_t stateNext;

  // Postscaler tap for a given frequency code
  function automatic logic postTap(input logic [2:0] code, input logic [7:0] div,
                                   input logic fast, input logic slow, input logic lfs);
    logic r;
    r = fast;
    case (code)
      scsr_pkg::FREQ_8M:  r = fast;
      scsr_pkg::FREQ_31K: r = lfs ? div[7] : slow;
      default:            r = div[6 - code];
    endcase
    return r;
  endfunction : postTap

  logic internalClk;
  logic primaryClk;
  logic secAllowed;
  logic accessOk;

  // Candidate sources, recomputed every cycle so frequency changes act at once
  always_comb begin
    internalClk = postTap(stateReg.cfg.freqSel, stateReg.postDiv, osc.fastOsc,
                          osc.slowRcOsc, stateReg.cfg.lowFreqSrc);
    primaryClk  = (primaryOscConfig == scsr_pkg::CFG_POST0 || primaryOscConfig == scsr_pkg::CFG_POST1)
                  ? internalClk : osc.coreDivClk;
    secAllowed  = stateReg.cfg.secXtalEn | secondaryDigitalInput;
  end

  // Source mux shared by the switch logic
  function automatic logic srcClk(input scsr_pkg::scsr_src_t s, input logic pri,
                                  input logic sec, input logic intc);
    logic r;
    r = pri;
    case (s)
      scsr_pkg::SRC_SECONDARY: r = sec;
      scsr_pkg::SRC_INTERNAL:  r = intc;
      default:                 r = pri;
    endcase
    return r;
  endfunction : srcClk

  logic oldClk;
  logic newClk;
  logic baseClk;
  logic refTap;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    accessOk  = 1'b0;
    oldClk    = srcClk(stateReg.activeSrc, primaryClk, osc.secondaryOsc, internalClk);
    newClk    = srcClk(stateReg.pendSrc, primaryClk, osc.secondaryOsc, internalClk);
    baseClk   = stateReg.cfg.refSrcSel ? osc.primaryClk : stateReg.devClk;
    refTap    = (stateReg.cfg.refDiv == 4'h0) ? baseClk
              : stateReg.refCnt[4'(stateReg.cfg.refDiv - 4'h1)];

    // Postscaler counter on the fast oscillator
    stateNext.prevFast = osc.fastOsc;
    if (osc.fastOsc && !stateReg.prevFast) begin
      stateNext.postDiv = stateReg.postDiv + 8'h01;
    end

    // Start-up status captured at reset release, then tracks the timer
    if (!stateReg.statusInit) begin
      stateNext.statusInit    = 1'b1;
      stateNext.startupStatus = ~twoSpeedStartup;
    end else begin
      stateNext.startupStatus = startupTimerDone & (stateReg.activeSrc == scsr_pkg::SRC_PRIMARY)
                                & (stateReg.swState == scsr_pkg::SW_RUN);
    end

    // Glitch-free switch: hold low over old then new edges
    stateNext.prevOld = oldClk;
    stateNext.prevNew = newClk;
    case (stateReg.swState)
      scsr_pkg::SW_RUN: begin
        stateNext.devClk = oldClk;
        if (stateReg.pendSrc != stateReg.activeSrc) begin
          stateNext.swState = scsr_pkg::SW_OLD;
          stateNext.swCount = 3'h0;
        end
      end
      scsr_pkg::SW_OLD: begin
        stateNext.devClk = 1'b0;
        if (oldClk && !stateReg.prevOld) begin
          stateNext.swCount = stateReg.swCount + 3'h1;
          if (stateReg.swCount == 3'(scsr_pkg::SWITCH_OLD - 1)) begin
            stateNext.swState = scsr_pkg::SW_NEW;
            stateNext.swCount = 3'h0;
          end
        end
      end
      scsr_pkg::SW_NEW: begin
        stateNext.devClk = 1'b0;
        if (newClk && !stateReg.prevNew) begin
          stateNext.swCount = stateReg.swCount + 3'h1;
          if (stateReg.swCount == 3'(scsr_pkg::SWITCH_NEW - 2)) begin
            stateNext.swState   = scsr_pkg::SW_RUN;
            stateNext.activeSrc = stateReg.pendSrc;
          end
        end
      end
      default: stateNext.swState = scsr_pkg::SW_RUN;
    endcase

    // Reference divider counts base clock edges
    stateNext.prevBase = baseClk;
    if (baseClk && !stateReg.prevBase) begin
      stateNext.refCnt = stateReg.refCnt + DIV_WIDTH'(1);
    end
    stateNext.refOut = stateReg.cfg.refEn & refTap &
                       (~sleepActive | (stateReg.cfg.refSleepCont & stateReg.cfg.refSrcSel & extOrHsMode));

    // Register bus: one cycle of wait, then answer
    stateNext.ack = 1'b0;
    if ((read || write) && !stateReg.ack) begin
      stateNext.ack = 1'b1;
      accessOk      = 1'b1;
    end
    // Writes land at the edge where waitrequest is low, never in the wait cycle
    if (write && stateReg.ack && byteenable[0]) begin
      case (address)
        scsr_pkg::OSC_CTRL_ADDR: begin
          stateNext.cfg.idleEn  = writedata[scsr_pkg::IDLE_BIT];
          stateNext.cfg.freqSel = writedata[scsr_pkg::FREQ_LSB +: 3];
          if (writedata[scsr_pkg::SRC_LSB +: 2] == 2'(scsr_pkg::SRC_SECONDARY) && !secAllowed) begin
            stateNext.cfg.srcSel = stateReg.cfg.srcSel;
          end else begin
            stateNext.cfg.srcSel = scsr_pkg::scsr_src_t'(writedata[scsr_pkg::SRC_LSB +: 2]);
          end
        end
        scsr_pkg::TUNE_ADDR:     stateNext.cfg.lowFreqSrc = writedata[scsr_pkg::LFSRC_BIT];
        scsr_pkg::SEC_CTRL_ADDR: stateNext.cfg.secXtalEn  = writedata[scsr_pkg::SECXTAL_BIT];
        scsr_pkg::REF_CTRL_ADDR: begin
          stateNext.cfg.refEn        = writedata[scsr_pkg::REFEN_BIT];
          stateNext.cfg.refSleepCont = writedata[scsr_pkg::REFSLP_BIT];
          stateNext.cfg.refSrcSel    = writedata[scsr_pkg::REFSEL_BIT];
          stateNext.cfg.refDiv       = writedata[3:0];
        end
        default: ;
      endcase
    end
    // Reserved code maps to primary as the running target
    stateNext.pendSrc = (stateNext.cfg.srcSel == scsr_pkg::SRC_RESERVED)
                        ? scsr_pkg::SRC_PRIMARY : stateNext.cfg.srcSel;
    if (accessOk && read) begin
      case (address)
        scsr_pkg::OSC_CTRL_ADDR: stateNext.rdData = {24'h000000, stateReg.cfg.idleEn, stateReg.cfg.freqSel,
                                                     stateReg.startupStatus, 1'b1, stateReg.cfg.srcSel};
        scsr_pkg::TUNE_ADDR:     stateNext.rdData = {24'h000000, stateReg.cfg.lowFreqSrc, 7'h00};
        scsr_pkg::SEC_CTRL_ADDR: stateNext.rdData = {24'h000000, 1'b0,
                                                     stateReg.activeSrc == scsr_pkg::SRC_SECONDARY
                                                     && stateReg.swState == scsr_pkg::SW_RUN,
                                                     2'h0, stateReg.cfg.secXtalEn, 3'h0};
        scsr_pkg::REF_CTRL_ADDR: stateNext.rdData = {24'h000000, stateReg.cfg.refEn, 1'b0,
                                                     stateReg.cfg.refSleepCont, stateReg.cfg.refSrcSel,
                                                     stateReg.cfg.refDiv};
        default:                 stateNext.rdData = {24'h000000, scsr_pkg::UNMAPPED_RD};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateReg             <= '0;
      stateReg.cfg.freqSel <= scsr_pkg::FREQ_RESET;
      stateReg.cfg.srcSel  <= scsr_pkg::SRC_PRIMARY;
      stateReg.activeSrc   <= scsr_pkg::SRC_PRIMARY;
      stateReg.pendSrc     <= scsr_pkg::SRC_PRIMARY;
      stateReg.swState     <= scsr_pkg::SW_RUN;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs; device clock is a registered copy to stay glitch-free
  assign readdata           = stateReg.rdData;
  assign waitrequest        = (read | write) & ~stateReg.ack;
  assign deviceClk          = stateReg.devClk;
  assign watchdogClk        = osc.slowRcOsc;
  assign haltEntersIdle     = stateReg.cfg.idleEn;
  assign referenceOutputPin = stateReg.refOut;
  assign referenceOutputEn  = stateReg.cfg.refEn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence swPause;
    stateReg.swState != scsr_pkg::SW_RUN;
  endsequence

  AST_RESERVED_SAFE: assert property (@(posedge clock) disable iff (!rst_n)
    stateReg.activeSrc != scsr_pkg::SRC_RESERVED) else $error("active source is reserved");
  AST_PAUSE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    swPause |=> (deviceClk == 1'b0) || (stateReg.swState == scsr_pkg::SW_RUN))
    else $error("device clock toggled during switch");
  AST_SWITCH_START: assert property (@(posedge clock) disable iff (!rst_n)
    (stateReg.swState == scsr_pkg::SW_RUN && stateReg.pendSrc != stateReg.activeSrc) |=> swPause)
    else $error("switch did not start");
  AST_SEC_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
    (write && !waitrequest && address == scsr_pkg::OSC_CTRL_ADDR && byteenable[0]
     && writedata[1:0] == 2'h1 && !stateReg.cfg.secXtalEn && !secondaryDigitalInput
     && stateReg.cfg.srcSel != scsr_pkg::SRC_SECONDARY)
    |=> stateReg.cfg.srcSel != scsr_pkg::SRC_SECONDARY) else $error("secondary select not ignored");
  AST_WDT_CLK: assert property (@(posedge clock) disable iff (!rst_n)
    watchdogClk == osc.slowRcOsc) else $error("watchdog clock not slow RC");
  AST_REF_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    !stateReg.cfg.refEn |=> !referenceOutputPin) else $error("reference pin active while disabled");
  AST_REF_SLEEP: assert property (@(posedge clock) disable iff (!rst_n)
    (sleepActive && !stateReg.cfg.refSleepCont) |=> !referenceOutputPin)
    else $error("reference ran in sleep");
  AST_STATUS_EXCL: assert property (@(posedge clock) disable iff (!rst_n)
    !(stateReg.startupStatus && stateReg.statusInit && stateReg.activeSrc == scsr_pkg::SRC_SECONDARY
      && $past(stateReg.activeSrc) == scsr_pkg::SRC_SECONDARY)) else $error("both status bits set");
  AST_BUS_ANSWER: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(read) || $rose(write)) |-> ##[0:1] !waitrequest) else $error("bus answer late");

endmodule : scsr_clock_select

// *** include/scsr_pkg.sv ***
// Package: register map, field layout, reset values and types of the clock select block
package scsr_pkg;

  // ----------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OSC_CTRL_IDX  = 12'hFD3; // oscillator_control index
  localparam logic [11:0] REF_CTRL_IDX  = 12'hF3D; // reference_control index
  localparam logic [11:0] TUNE_IDX      = 12'hF9B; // tuning_register index
  localparam logic [11:0] SEC_CTRL_IDX  = 12'h010; // secondary_timer_control index
  localparam logic [13:0] OSC_CTRL_ADDR = {OSC_CTRL_IDX, 2'h0};
  localparam logic [13:0] REF_CTRL_ADDR = {REF_CTRL_IDX, 2'h0};
  localparam logic [13:0] TUNE_ADDR     = {TUNE_IDX, 2'h0};
  localparam logic [13:0] SEC_CTRL_ADDR = {SEC_CTRL_IDX, 2'h0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IDLE_BIT     = 7;
  localparam int FREQ_LSB     = 4;
  localparam int STATUS_BIT   = 3;
  localparam int RSV_ONE_BIT  = 2;
  localparam int SRC_LSB      = 0;
  localparam int LFSRC_BIT    = 7;
  localparam int REFEN_BIT    = 7;
  localparam int REFSLP_BIT   = 5;
  localparam int REFSEL_BIT   = 4;
  localparam int SECRUN_BIT   = 6;
  localparam int SECXTAL_BIT  = 3;

  // ----------------------------------------------------------------
  // Values after reset and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] FREQ_RESET   = 3'h6; // 4 MHz postscaler
  localparam logic [2:0] FREQ_31K     = 3'h0;
  localparam logic [2:0] FREQ_8M      = 3'h7;
  localparam logic [2:0] CFG_POST0    = 3'h0;
  localparam logic [2:0] CFG_POST1    = 3'h1;
  localparam int         SWITCH_OLD   = 2;     // old-clock cycles of the pause
  localparam int         SWITCH_NEW   = 4;     // one more than the new-clock cycles of the pause
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_RESERVED  = 2'h2,
    SRC_INTERNAL  = 2'h3
  } scsr_src_t;

  typedef enum {SW_RUN, SW_OLD, SW_NEW} scsr_sw_t;

  // Software-visible configuration
  typedef struct packed {
    logic       idleEn;
    logic [2:0] freqSel;
    scsr_src_t  srcSel;
    logic       lowFreqSrc;
    logic       refEn;
    logic       refSleepCont;
    logic       refSrcSel;
    logic [3:0] refDiv;
    logic       secXtalEn;
  } scsr_cfg_t;

  // Oscillator inputs, sampled as ordinary synchronous levels
  typedef struct packed {
    logic primaryClk;
    logic coreDivClk;
    logic fastOsc;
    logic slowRcOsc;
    logic secondaryOsc;
  } scsr_osc_t;

endpackage : scsr_pkg

// *** verification/scsr_osc_model.sv ***
// Oscillator source model: free-running primary, core divider, fast, slow RC and secondary clocks
`timescale 1ns/1ps

module scsr_osc_model (
  // Bench clock
  input  wire logic          clock,
  // Oscillator levels toward the block
  output scsr_pkg::scsr_osc_t osc
);

  int cycleCount;

  // ----------------------------------------------------------------
  // Source waveforms
  // ----------------------------------------------------------------
  // All periods stay well below half the sampling rate so every level is seen
  initial begin
    cycleCount = 0;
    osc        = '0;
  end

  // Secondary crystal runs from time zero, so it is stable before any selection
  always @(posedge clock) begin
    cycleCount          <= cycleCount + 1;
    osc.primaryClk      <= ((cycleCount % 8) < 4);
    osc.coreDivClk      <= ((cycleCount % 6) < 3);
    osc.fastOsc         <= ((cycleCount % 4) < 2);
    osc.slowRcOsc       <= ((cycleCount % 10) < 5);
    osc.secondaryOsc    <= ((cycleCount % 12) < 6);
  end

endmodule : scsr_osc_model

// *** verification/scsr_clock_select_tb.sv ***
// Testbench: register access, clock selection, status bits and reference output checks
`timescale 1ns/1ps

module scsr_clock_select_tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                clock;
  logic                rst_n;
  logic [13:0]         address;
  logic                read;
  logic                write;
  logic [3:0]          byteenable;
  logic [31:0]         writedata;
  logic [31:0]         readdata;
  logic                waitrequest;
  scsr_pkg::scsr_osc_t osc;
  logic [2:0]          primaryOscConfig;
  logic                secondaryDigitalInput;
  logic                twoSpeedStartup;
  logic                startupTimerDone;
  logic                extOrHsMode;
  logic                sleepActive;
  logic                deviceClk;
  logic                watchdogClk;
  logic                haltEntersIdle;
  logic                referenceOutputPin;
  logic                referenceOutputEn;
  int                  n_mismatch;
  int                  check_count;
  logic [7:0]          rdVal;
  int                  nDev;
  int                  nRef;

  scsr_clock_select i_dut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .osc(osc), .primaryOscConfig(primaryOscConfig), .secondaryDigitalInput(secondaryDigitalInput),
    .twoSpeedStartup(twoSpeedStartup), .startupTimerDone(startupTimerDone), .extOrHsMode(extOrHsMode),
    .sleepActive(sleepActive), .deviceClk(deviceClk), .watchdogClk(watchdogClk),
    .haltEntersIdle(haltEntersIdle), .referenceOutputPin(referenceOutputPin),
    .referenceOutputEn(referenceOutputEn)
  );

  scsr_osc_model i_osc (.clock(clock), .osc(osc));

  // Clock at 20 MHz
  always #25 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  // Request held until waitrequest is sampled low; the bench never assumes a latency
  task automatic bus(input logic isWr, input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address   <= a;
    writedata <= {24'h000000, d};
    write     <= isWr;
    read      <= ~isWr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    if (n >= 20) n_mismatch++;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [13:0] a, input logic [7:0] exp, input logic [7:0] mask);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, exp & mask, q & mask);
  endtask : rdchk

  // Edge counts only; phase of the sampled sources allows a small tolerance
  task automatic chkr(input string nm, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chkr

  task automatic edges(input int n, output int dv, output int rf);
    logic pd;
    logic pr;
    dv = 0;
    rf = 0;
    pd = deviceClk;
    pr = referenceOutputPin;
    repeat (n) begin
      @(posedge clock);
      if (deviceClk === 1'b1 && pd !== 1'b1) dv++;
      if (referenceOutputPin === 1'b1 && pr !== 1'b1) rf++;
      pd = deviceClk;
      pr = referenceOutputPin;
    end
  endtask : edges

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Watchdog: the sequence needs about 7400 cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0; rst_n = 1'b0; address = '0; read = 1'b0; write = 1'b0; byteenable = 4'hF;
    writedata = '0; primaryOscConfig = 3'h2; secondaryDigitalInput = 1'b0; twoSpeedStartup = 1'b0;
    startupTimerDone = 1'b1; extOrHsMode = 1'b1; sleepActive = 1'b0;
    n_mismatch = 0; check_count = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values and the watchdog clock path
    rdchk("osc_ctrl", scsr_pkg::OSC_CTRL_ADDR, 8'h6C, 8'hFF);
    rdchk("ref_ctrl", scsr_pkg::REF_CTRL_ADDR, 8'h00, 8'hFF);
    rdchk("unmapped", 14'h0100, 8'h00, 8'hFF);
    repeat (20) begin
      @(posedge clock);
      chk("watchdogClk", {7'h00, osc.slowRcOsc}, {7'h00, watchdogClk});
    end
    $display("test reset done");
    // Start-up status follows the timer
    startupTimerDone <= 1'b0;
    repeat (4) @(posedge clock);
    rdchk("status_low", scsr_pkg::OSC_CTRL_ADDR, 8'h64, 8'hFF);
    startupTimerDone <= 1'b1;
    repeat (4) @(posedge clock);
    rdchk("status_high", scsr_pkg::OSC_CTRL_ADDR, 8'h6C, 8'hFF);
    $display("test status done");
    // Secondary refused without crystal, then taken
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'h61);
    rdchk("sec_refused", scsr_pkg::OSC_CTRL_ADDR, 8'h6C, 8'hFF);
    wr(scsr_pkg::SEC_CTRL_ADDR, 8'h08);
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'h61);
    repeat (60) @(posedge clock);
    rdchk("sec_src", scsr_pkg::OSC_CTRL_ADDR, 8'h65, 8'hFF);
    rdchk("sec_run", scsr_pkg::SEC_CTRL_ADDR, 8'h48, 8'hFF);
    edges(480, nDev, nRef);
    chkr("dev_sec", 38, 42, nDev);
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'h62);
    repeat (60) @(posedge clock);
    rdchk("reserved", scsr_pkg::OSC_CTRL_ADDR, 8'h66, 8'hF7);
    rdchk("sec_off", scsr_pkg::SEC_CTRL_ADDR, 8'h08, 8'hFF);
    edges(480, nDev, nRef);
    chkr("dev_reserved", 78, 82, nDev);
    $display("test source done");
    // Internal postscaler: 8 MHz, 4 MHz, 2 MHz settings, then slow RC at 31 kHz
    for (int f = 7; f >= 5; f--) begin
      wr(scsr_pkg::OSC_CTRL_ADDR, {1'b0, f[2:0], 4'h3});
      repeat (40) @(posedge clock);
      edges(480, nDev, nRef);
      chkr("dev_internal", (120 >> (7 - f)) - 2, (120 >> (7 - f)) + 2, nDev);
    end
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'h03);
    repeat (40) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("dev_slow_rc", 46, 50, nDev);
    wr(scsr_pkg::TUNE_ADDR, 8'h80);
    repeat (40) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("dev_fast_256", 0, 1, nDev);
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'hE0);
    repeat (60) @(posedge clock);
    chk("idle", 8'h01, {7'h00, haltEntersIdle});
    wr(scsr_pkg::OSC_CTRL_ADDR, 8'h60);
    repeat (60) @(posedge clock);
    chk("sleep", 8'h00, {7'h00, haltEntersIdle});
    $display("test internal done");
    // Reference output: primary crystal base divided by 1, 2, 4; then system clock base
    for (int d = 0; d < 3; d++) begin
      wr(scsr_pkg::REF_CTRL_ADDR, 8'h90 | d[7:0]);
      repeat (20) @(posedge clock);
      edges(480, nDev, nRef);
      chkr("ref_div", (60 >> d) - 2, (60 >> d) + 2, nRef);
    end
    chk("ref_en", 8'h01, {7'h00, referenceOutputEn});
    wr(scsr_pkg::REF_CTRL_ADDR, 8'h8F);
    repeat (20) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("ref_div_max", 0, 1, nRef);
    wr(scsr_pkg::REF_CTRL_ADDR, 8'h80);
    repeat (20) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("ref_sys", 78, 82, nRef);
    // Sleep: output continues only with sleep-continue and crystal source
    sleepActive <= 1'b1;
    wr(scsr_pkg::REF_CTRL_ADDR, 8'hB0);
    repeat (20) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("ref_sleep_on", 58, 62, nRef);
    wr(scsr_pkg::REF_CTRL_ADDR, 8'h90);
    repeat (20) @(posedge clock);
    edges(480, nDev, nRef);
    chkr("ref_sleep_off", 0, 1, nRef);
    sleepActive <= 1'b0;
    wr(scsr_pkg::REF_CTRL_ADDR, 8'h00);
    repeat (4) @(posedge clock);
    chk("ref_dis", 8'h00, {7'h00, referenceOutputEn});
    $display("test reference done");
    results();
  end

endmodule : scsr_clock_select_tb
